//--- core/afc_defines.svh
// Constants for the output format configuration bank
// Notes on behaviour
// - A high-then-low pulse on load trigger bit 0 reloads configuration.
// - Channel B selector bits 7:5: 000 normal, 010 ramp, 011 constant.
// - Channel A selector bits 4:2: 000 normal, 010 ramp, 011 constant.
// - Ramp mode adds the 18-bit pattern value to every successive sample.
// - Constant mode repeats the pattern value, aligned to the word's top end.
// - Pattern value bits 17:16 at 0x16, 15:8 at 0x15, 7:0 at 0x14.
// - Frame clock setup: source bit 7, divide bit 4, toggle bit 0, rest zero.
// - Swing register bit 6 set reduces serial output swing; clear restores full.
// - Resolution bit 7 enables the width trim block; not needed for 20 bits.
// - Resolution bit 6 set selects a 20-bit output word.
// - Width choice bits 5:3: 000 18 bits, 001 16 bits, 010 14 bits.
// - With DSP path off, width choice acts only while trim enable is 1.
// - DSP path enable lets width choice act without trim enable; frame clock bits pass through unchanged.
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

`define AFC_OFS_LOAD 7'h13
`define AFC_OFS_PAT_LOW 7'h14
`define AFC_OFS_PAT_MID 7'h15
`define AFC_OFS_PAT_HIGH 7'h16
`define AFC_OFS_FRAME_CLK 7'h19
`define AFC_OFS_SWING 7'h1a
`define AFC_OFS_RESOLUTION 7'h1b

`define AFC_REG_RESET 8'h00
`define AFC_BIT_LOAD 0
`define AFC_BIT_FRAME_CLK_SOURCE 7
`define AFC_BIT_FRAME_CLK_DIVIDE 4
`define AFC_BIT_FRAME_CLOCK_TOG 0
`define AFC_BIT_SWING 6
`define AFC_BIT_TRIM_ON 7
`define AFC_BIT_WIDE_ON 6
`define AFC_WCH_HI 5
`define AFC_WCH_LO 3
`define AFC_PB_HI 7
`define AFC_PB_LO 5
`define AFC_PA_HI 4
`define AFC_PA_LO 2
`define AFC_PV_HI_HI 1
`define AFC_PV_HI_LO 0

`define AFC_MODE_NORMAL 3'h0
`define AFC_MODE_RAMP 3'h2
`define AFC_MODE_CONST 3'h3
`define AFC_WCH_18 3'h0
`define AFC_WCH_16 3'h1
`define AFC_WCH_14 3'h2

`define AFC_MASK_20 20'hf_ffff
`define AFC_MASK_18 20'hf_fffc
`define AFC_MASK_16 20'hf_fff0
`define AFC_MASK_14 20'hf_ffc0

`define AFC_SPI_FRAME_BITS 5'h10
`define AFC_SPI_ADDR_BITS 5'h08
`define AFC_SPI_ZERO_PAD 2'h0

`endif

//--- core/afc_pkg.sv
// Types shared by the output format configuration bank
package afc_pkg;
  typedef logic [17:0] afc_sample_t;
  typedef logic [19:0] afc_word_t;
  typedef logic [7:0] afc_byte_t;
  typedef logic [2:0] afc_mode_t;
endpackage : afc_pkg

//--- core/afc_pat_if.sv
// Carrier between the register bank and a channel pattern generator
interface afc_pat_if;
  import afc_pkg::*;
  afc_mode_t mode;
  afc_sample_t value;
  logic sample_valid;
  modport src (output mode, output value, output sample_valid);
  modport gen (input mode, input value, input sample_valid);
endinterface : afc_pat_if

//--- core/afc_pattern_gen.sv
// Per-channel test pattern generator: normal, ramp or constant
`include "afc_defines.svh"
module afc_pattern_gen (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Settings and sample strobe
  afc_pat_if.gen pat,
  // Converter sample
  input wire afc_pkg::afc_sample_t adc_sample_in,
  // Selected sample
  output afc_pkg::afc_sample_t sample_out
);
  import afc_pkg::*;

  afc_sample_t acc_reg;
  afc_sample_t sample_reg;

  // Ramp restarts from zero whenever another mode is picked
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      acc_reg <= '0;
    end else if (pat.mode != `AFC_MODE_RAMP) begin
      acc_reg <= '0;
    end else if (pat.sample_valid) begin
      acc_reg <= acc_reg + pat.value;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sample_reg <= '0;
    end else if (pat.sample_valid) begin
      unique case (pat.mode)
        `AFC_MODE_RAMP: sample_reg <= acc_reg;
        `AFC_MODE_CONST: sample_reg <= pat.value;
        default: sample_reg <= adc_sample_in;
      endcase
    end
  end

  assign sample_out = sample_reg;

  AST_RAMP_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pat.mode == `AFC_MODE_RAMP && pat.sample_valid)
      |=> acc_reg == afc_sample_t'($past(acc_reg) + $past(pat.value)))
    else $error("ramp accumulator did not advance by the step");

  AST_RAMP_OUT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pat.mode == `AFC_MODE_RAMP && pat.sample_valid) |=> sample_out == $past(acc_reg))
    else $error("ramp sample not taken from the accumulator");

  AST_RAMP_WRAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pat.mode == `AFC_MODE_RAMP && pat.sample_valid && afc_sample_t'(acc_reg + pat.value) < acc_reg)
      |=> acc_reg < $past(acc_reg))
    else $error("ramp accumulator did not wrap");

  AST_CONST_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pat.mode == `AFC_MODE_CONST && pat.sample_valid) |=> sample_out == $past(pat.value))
    else $error("constant pattern not output");
endmodule : afc_pattern_gen

//--- core/afc_output_format_cfg.sv
// Output format configuration bank with serial register port and pattern paths
`include "afc_defines.svh"
module afc_output_format_cfg (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Serial register port
  input wire logic spi_sclk_in,
  input wire logic spi_sen_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  // Data path state from elsewhere in the device
  input wire logic dsp_path_on_in,
  input wire logic sample_valid_in,
  input wire afc_pkg::afc_sample_t adc_a_sample_in,
  input wire afc_pkg::afc_sample_t adc_b_sample_in,
  // Formatted output words
  output afc_pkg::afc_word_t out_a_word_out,
  output afc_pkg::afc_word_t out_b_word_out,
  // Configuration effects
  output logic config_load_pulse_out,
  output logic frame_clk_source_out,
  output logic frame_clk_divide_out,
  output logic frame_clk_toggle_out,
  output logic half_swing_out,
  output logic wide_output_out
);
  import afc_pkg::*;

  // Register storage; only documented fields are kept, the rest read zero
  logic config_load_trigger_reg;
  afc_byte_t test_pattern_low_reg;
  afc_byte_t test_pattern_mid_reg;
  logic [1:0] pattern_value_top_reg;
  afc_mode_t pattern_a_select_reg;
  afc_mode_t pattern_b_select_reg;
  logic frame_clk_source_reg;
  logic frame_clk_divide_reg;
  logic frame_clk_toggle_reg;
  logic half_swing_reg;
  logic width_trim_on_reg;
  logic wide_output_on_reg;
  afc_mode_t width_choice_reg;

  // Serial port, load edge and output word state
  logic sclk_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  afc_byte_t sdo_shift_reg;
  logic load_prev_reg;
  logic load_pulse_reg;
  afc_word_t out_a_reg;
  afc_word_t out_b_reg;

  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] shift_next;
  logic wr_en;
  logic [6:0] wr_addr;
  afc_byte_t wr_data;
  logic [6:0] rd_addr;
  afc_byte_t rd_data;
  afc_sample_t pattern_value;
  afc_sample_t sample_a;
  afc_sample_t sample_b;
  afc_word_t trim_mask;

  // Frame: read flag, 7-bit address, 8 data bits, most significant first
  assign sclk_rise = spi_sclk_in && !sclk_prev_reg && !spi_sen_n_in;
  assign sclk_fall = !spi_sclk_in && sclk_prev_reg && !spi_sen_n_in;
  assign shift_next = {shift_reg[14:0], spi_sdi_in};
  assign wr_en = sclk_rise && (bit_cnt_reg == `AFC_SPI_FRAME_BITS - 5'h01) && !shift_reg[14];
  assign wr_addr = shift_next[14:8];
  assign wr_data = shift_next[7:0];
  assign rd_addr = shift_next[6:0];

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= spi_sclk_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end else if (spi_sen_n_in) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise && bit_cnt_reg != `AFC_SPI_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg <= shift_next;
    end
  end

  // Readback is loaded after the address and shifted out on falling edges
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sdo_shift_reg <= '0;
    end else if (sclk_rise && bit_cnt_reg == `AFC_SPI_ADDR_BITS - 5'h01) begin
      sdo_shift_reg <= shift_next[7] ? rd_data : `AFC_REG_RESET;
    end else if (sclk_fall && bit_cnt_reg > `AFC_SPI_ADDR_BITS) begin
      sdo_shift_reg <= {sdo_shift_reg[6:0], 1'b0};
    end
  end

  assign spi_sdo_out = sdo_shift_reg[7];

  always_comb begin
    rd_data = `AFC_REG_RESET;
    unique case (rd_addr)
      `AFC_OFS_LOAD: rd_data[`AFC_BIT_LOAD] = config_load_trigger_reg;
      `AFC_OFS_PAT_LOW: rd_data = test_pattern_low_reg;
      `AFC_OFS_PAT_MID: rd_data = test_pattern_mid_reg;
      `AFC_OFS_PAT_HIGH: rd_data = {pattern_b_select_reg, pattern_a_select_reg, pattern_value_top_reg};
      `AFC_OFS_FRAME_CLK: begin
        rd_data[`AFC_BIT_FRAME_CLK_SOURCE] = frame_clk_source_reg;
        rd_data[`AFC_BIT_FRAME_CLK_DIVIDE] = frame_clk_divide_reg;
        rd_data[`AFC_BIT_FRAME_CLOCK_TOG] = frame_clk_toggle_reg;
      end
      `AFC_OFS_SWING: rd_data[`AFC_BIT_SWING] = half_swing_reg;
      `AFC_OFS_RESOLUTION: begin
        rd_data[`AFC_BIT_TRIM_ON] = width_trim_on_reg;
        rd_data[`AFC_BIT_WIDE_ON] = wide_output_on_reg;
        rd_data[`AFC_WCH_HI:`AFC_WCH_LO] = width_choice_reg;
      end
      default: rd_data = `AFC_REG_RESET;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      config_load_trigger_reg <= 1'b0;
    end else if (wr_en && wr_addr == `AFC_OFS_LOAD) begin
      config_load_trigger_reg <= wr_data[`AFC_BIT_LOAD];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      test_pattern_low_reg <= `AFC_REG_RESET;
      test_pattern_mid_reg <= `AFC_REG_RESET;
      pattern_value_top_reg <= '0;
      pattern_a_select_reg <= `AFC_MODE_NORMAL;
      pattern_b_select_reg <= `AFC_MODE_NORMAL;
    end else if (wr_en) begin
      if (wr_addr == `AFC_OFS_PAT_LOW) begin
        test_pattern_low_reg <= wr_data;
      end
      if (wr_addr == `AFC_OFS_PAT_MID) begin
        test_pattern_mid_reg <= wr_data;
      end
      if (wr_addr == `AFC_OFS_PAT_HIGH) begin
        pattern_value_top_reg <= wr_data[`AFC_PV_HI_HI:`AFC_PV_HI_LO];
        pattern_b_select_reg <= wr_data[`AFC_PB_HI:`AFC_PB_LO];
        pattern_a_select_reg <= wr_data[`AFC_PA_HI:`AFC_PA_LO];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      frame_clk_source_reg <= 1'b0;
      frame_clk_divide_reg <= 1'b0;
      frame_clk_toggle_reg <= 1'b0;
    end else if (wr_en && wr_addr == `AFC_OFS_FRAME_CLK) begin
      frame_clk_source_reg <= wr_data[`AFC_BIT_FRAME_CLK_SOURCE];
      frame_clk_divide_reg <= wr_data[`AFC_BIT_FRAME_CLK_DIVIDE];
      frame_clk_toggle_reg <= wr_data[`AFC_BIT_FRAME_CLOCK_TOG];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      half_swing_reg <= 1'b0;
    end else if (wr_en && wr_addr == `AFC_OFS_SWING) begin
      half_swing_reg <= wr_data[`AFC_BIT_SWING];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      width_trim_on_reg <= 1'b0;
      wide_output_on_reg <= 1'b0;
      width_choice_reg <= `AFC_WCH_18;
    end else if (wr_en && wr_addr == `AFC_OFS_RESOLUTION) begin
      width_trim_on_reg <= wr_data[`AFC_BIT_TRIM_ON];
      wide_output_on_reg <= wr_data[`AFC_BIT_WIDE_ON];
      width_choice_reg <= wr_data[`AFC_WCH_HI:`AFC_WCH_LO];
    end
  end

  // The host owns the one-millisecond hold; the device acts on the falling edge only
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      load_prev_reg <= 1'b0;
      load_pulse_reg <= 1'b0;
    end else begin
      load_prev_reg <= config_load_trigger_reg;
      load_pulse_reg <= load_prev_reg && !config_load_trigger_reg;
    end
  end

  assign config_load_pulse_out = load_pulse_reg;
  // Host picks these per DSP and lane mode; the device passes them on
  assign frame_clk_source_out = frame_clk_source_reg;
  assign frame_clk_divide_out = frame_clk_divide_reg;
  assign frame_clk_toggle_out = frame_clk_toggle_reg;
  assign half_swing_out = half_swing_reg;
  assign wide_output_out = wide_output_on_reg;
  assign pattern_value = {pattern_value_top_reg, test_pattern_mid_reg, test_pattern_low_reg};

  afc_pat_if pat_a ();
  afc_pat_if pat_b ();
  assign pat_a.mode = pattern_a_select_reg;
  assign pat_a.value = pattern_value;
  assign pat_a.sample_valid = sample_valid_in;
  assign pat_b.mode = pattern_b_select_reg;
  assign pat_b.value = pattern_value;
  assign pat_b.sample_valid = sample_valid_in;

  afc_pattern_gen gen_a (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pat(pat_a.gen),
    .adc_sample_in(adc_a_sample_in),
    .sample_out(sample_a)
  );

  afc_pattern_gen gen_b (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pat(pat_b.gen),
    .adc_sample_in(adc_b_sample_in),
    .sample_out(sample_b)
  );

  // Twenty-bit mode bypasses the trim block; a reserved code keeps 18 bits
  always_comb begin
    trim_mask = `AFC_MASK_18;
    if (wide_output_on_reg) begin
      trim_mask = `AFC_MASK_20;
    end else if (dsp_path_on_in || width_trim_on_reg) begin
      unique case (width_choice_reg)
        `AFC_WCH_16: trim_mask = `AFC_MASK_16;
        `AFC_WCH_14: trim_mask = `AFC_MASK_14;
        default: trim_mask = `AFC_MASK_18;
      endcase
    end
  end

  // Samples sit at the top of the word so narrower widths drop LSBs
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      out_a_reg <= '0;
      out_b_reg <= '0;
    end else begin
      out_a_reg <= {sample_a, `AFC_SPI_ZERO_PAD} & trim_mask;
      out_b_reg <= {sample_b, `AFC_SPI_ZERO_PAD} & trim_mask;
    end
  end

  assign out_a_word_out = out_a_reg;
  assign out_b_word_out = out_b_reg;

  AST_LOAD_PULSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(config_load_trigger_reg) |=> config_load_pulse_out ##1 !config_load_pulse_out)
    else $error("load pulse missing after trigger cleared");

  AST_LOAD_ONLY_ON_FALL: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    config_load_pulse_out |-> $past(config_load_trigger_reg, 2) && !$past(config_load_trigger_reg))
    else $error("load pulse without a falling trigger");

  AST_FRAME_CLOCK_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_en && wr_addr == `AFC_OFS_FRAME_CLK) |=> frame_clk_source_out == $past(wr_data[`AFC_BIT_FRAME_CLK_SOURCE])
      && frame_clk_divide_out == $past(wr_data[`AFC_BIT_FRAME_CLK_DIVIDE])
      && frame_clk_toggle_out == $past(wr_data[`AFC_BIT_FRAME_CLOCK_TOG]))
    else $error("frame clock fields misplaced");

  AST_SWING: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_en && wr_addr == `AFC_OFS_SWING) |=> half_swing_out == $past(wr_data[`AFC_BIT_SWING]))
    else $error("swing bit not taken from bit 6");

  AST_WIDE_FULL: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wide_output_on_reg |=> out_a_word_out == {$past(sample_a), 2'b00})
    else $error("20-bit word was trimmed");

  AST_TRIM_GATED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!dsp_path_on_in && !width_trim_on_reg && !wide_output_on_reg) |=> out_b_word_out[3:2] == $past(sample_b[1:0]))
    else $error("width choice applied without trim enable");

  AST_TRIM_14: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (width_trim_on_reg && !wide_output_on_reg && width_choice_reg == `AFC_WCH_14) |=> out_a_word_out[5:0] == 6'h00)
    else $error("14-bit word has low bits set");

  AST_PAT_VALUE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_en && wr_addr == `AFC_OFS_PAT_HIGH) |=> pattern_value[17:16] == $past(wr_data[1:0])
      && pattern_a_select_reg == $past(wr_data[4:2]) && pattern_b_select_reg == $past(wr_data[7:5]))
    else $error("pattern high register misassembled");
endmodule : afc_output_format_cfg

//--- bench/afc_host_model.sv
// Host model driving the serial register port of the format bank
module afc_host_model (
  // Clock
  input wire logic core_clk_in,
  // Serial port
  output logic spi_sclk_out,
  output logic spi_sen_n_out,
  output logic spi_sdi_out,
  input wire logic spi_sdo_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_sclk_out = 1'b0;
    spi_sen_n_out = 1'b1;
    spi_sdi_out = 1'b0;
  end

  // Rows: plain or real 2, 1, half wire; then complex 2, 1, half wire
  function automatic logic [7:0] frame_clock_byte(input int row);
    logic [7:0] t [6];
    t = '{8'h10, 8'h00, 8'h00, 8'h80, 8'h80, 8'h01};
    return t[row];
  endfunction : frame_clock_byte

  // Each serial clock level spans four core cycles, four times the one-cycle port minimum
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] f;
    f = {rd, addr, wdata};
    rdata = 8'h00;
    @(posedge core_clk_in);
    spi_sen_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_out <= f[i];
      spi_sclk_out <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      spi_sclk_out <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      if (i < 8) rdata[i] = spi_sdo_in;
    end
    repeat (4) @(posedge core_clk_in);
    // Released data line flips so a stale level never passes for data
    spi_sen_n_out <= 1'b1;
    spi_sclk_out <= 1'b0;
    spi_sdi_out <= ~f[0];
    repeat (4) @(posedge core_clk_in);
  endtask : xfer
endmodule : afc_host_model

//--- bench/test_adc_output_format_config.sv
// Self-checking bench for the output format configuration bank
module test_adc_output_format_config;
  timeunit 1ns;
  timeprecision 1ps;
  import afc_pkg::*;

  logic core_clk_in;
  logic rst_n_in;
  logic sclk, sen_n, sdi, sdo, dsp_on, valid;
  logic load_pulse, fsrc, fdiv, ftog, half_swing, wide_out;
  afc_sample_t adc_a, adc_b;
  afc_word_t out_a, out_b;
  int mismatches;
  int compares;
  int pulses = 0;
  logic [7:0] rdat;
  logic [6:0] reg_addr [7] = '{7'h13, 7'h14, 7'h15, 7'h16, 7'h19, 7'h1a, 7'h1b};
  logic [7:0] reg_mask [7] = '{8'h01, 8'hff, 8'hff, 8'hff, 8'h91, 8'h40, 8'hf8};

  afc_output_format_cfg afc_output_format_cfg_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .spi_sclk_in(sclk), .spi_sen_n_in(sen_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
    .dsp_path_on_in(dsp_on), .sample_valid_in(valid), .adc_a_sample_in(adc_a), .adc_b_sample_in(adc_b),
    .out_a_word_out(out_a), .out_b_word_out(out_b), .config_load_pulse_out(load_pulse),
    .frame_clk_source_out(fsrc), .frame_clk_divide_out(fdiv), .frame_clk_toggle_out(ftog),
    .half_swing_out(half_swing), .wide_output_out(wide_out));

  afc_host_model afc_host_model_i (.core_clk_in(core_clk_in), .spi_sclk_out(sclk), .spi_sen_n_out(sen_n),
    .spi_sdi_out(sdi), .spi_sdo_in(sdo));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) if (load_pulse === 1'b1) pulses <= pulses + 1;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    afc_host_model_i.xfer(1'b0, a, d, rdat);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    afc_host_model_i.xfer(1'b1, a, 8'h00, rdat);
    chk("register read", {12'h000, e}, {12'h000, rdat});
  endtask : rd_chk

  // Mask of the kept output bits for a resolution setting
  function automatic logic [19:0] exp_mask(input logic wide, input logic dsp, input logic trim, input logic [2:0] wch);
    if (wide) return 20'hf_ffff;
    if (!(dsp || trim)) return 20'hf_fffc;
    case (wch)
      3'h1: return 20'hf_fff0;
      3'h2: return 20'hf_ffc0;
      default: return 20'hf_fffc;
    endcase
  endfunction : exp_mask

  initial begin
    repeat (80000) @(posedge core_clk_in);
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    logic [17:0] v, s, step;
    logic [19:0] m;
    int p0;
    int unsigned ramp_acc;
    int unsigned ramp_q [$];
    rst_n_in = 1'b0;
    dsp_on = 1'b0;
    valid = 1'b0;
    adc_a = '0;
    adc_b = '0;
    mismatches = 0;
    compares = 0;
    r = $urandom(93264);
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    chk("effect outputs", 20'h0_0000, {14'h0000, load_pulse, fsrc, fdiv, ftog, half_swing, wide_out});
    chk("reset word a", 20'h0_0000, out_a);
    chk("reset word b", 20'h0_0000, out_b);
    for (int i = 0; i < 7; i++) rd_chk(reg_addr[i], 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) begin
      r = $urandom;
      wr(reg_addr[i], r[7:0]);
      rd_chk(reg_addr[i], r[7:0] & reg_mask[i]);
    end
    wr(7'h17, 8'hff);
    rd_chk(7'h17, 8'h00);
    for (int i = 0; i < 7; i++) wr(reg_addr[i], 8'h00);
    $display("test register_access done");
    for (int k = 0; k < 6; k++) begin
      r[7:0] = afc_host_model_i.frame_clock_byte(k);
      wr(7'h19, r[7:0]);
      chk("frame clock bits", {17'h0_0000, r[7], r[4], r[0]}, {17'h0_0000, fsrc, fdiv, ftog});
    end
    for (int k = 0; k < 2; k++) begin
      wr(7'h1a, {1'b0, k[0], 6'h00});
      chk("half swing", {19'h0_0000, k[0]}, {19'h0_0000, half_swing});
    end
    $display("test frame_clock_swing done");
    p0 = pulses;
    wr(7'h13, 8'h01);
    repeat (20000) @(posedge core_clk_in);
    chk("load pulses while held", p0[19:0], pulses[19:0]);
    wr(7'h13, 8'h00);
    chk("load pulses after clear", p0[19:0] + 20'h0_0001, pulses[19:0]);
    $display("test config_load done");
    r = $urandom;
    v = r[17:0];
    wr(7'h14, v[7:0]);
    wr(7'h15, v[15:8]);
    wr(7'h16, {3'b011, 3'b000, v[17:16]});
    valid <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      r = $urandom;
      s = r[17:0];
      dsp_on <= k[3];
      adc_a <= s;
      wr(7'h1b, {k[2], k[4], 1'b0, k[1:0], 3'b000});
      repeat (3) @(posedge core_clk_in);
      m = exp_mask(k[4], k[3], k[2], {1'b0, k[1:0]});
      chk("channel a normal word", {s, 2'b00} & m, out_a);
      chk("channel b constant word", {v, 2'b00} & m, out_b);
      chk("wide output", {19'h0_0000, k[4]}, {19'h0_0000, wide_out});
    end
    $display("test resolution_matrix done");
    wr(7'h1b, 8'h40);
    adc_b <= ~v;
    for (int c = 0; c < 8; c++) begin
      if (c == 2) continue;
      wr(7'h16, {c[2:0], c[2:0], v[17:16]});
      repeat (3) @(posedge core_clk_in);
      chk("channel a mode word", {(c == 3) ? v : s, 2'b00}, out_a);
      chk("channel b mode word", {(c == 3) ? v : ~v, 2'b00}, out_b);
    end
    $display("test mode_codes done");
    valid <= 1'b0;
    r = $urandom;
    step = r[17:0] | 18'h2_0000;
    wr(7'h14, step[7:0]);
    wr(7'h15, step[15:8]);
    wr(7'h16, {3'b010, 3'b010, step[17:16]});
    // Model: ramp starts at zero and wraps at two to the eighteenth
    ramp_acc = 0;
    for (int i = 0; i < 7; i++) begin
      ramp_q.push_back(ramp_acc);
      ramp_acc = (ramp_acc + step) % 262144;
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk_in);
      valid <= 1'b1;
      @(posedge core_clk_in);
      valid <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      r = ramp_q.pop_front();
      chk("channel a ramp", {r[17:0], 2'b00}, out_a);
      chk("channel b ramp", {r[17:0], 2'b00}, out_b);
    end
    $display("test ramp done");
    end_of_test();
  end
endmodule : test_adc_output_format_config
